// file: src/smc_consts.svh
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and reference timing
// ----------------------------------------------------------------
`define SMC_CLK_HZ 40000000
`define SMC_POLY_REF_HZ 10000
`define SMC_DRIVE_REF_HZ 5000
`define SMC_POLY_HALF (`SMC_CLK_HZ / (2 * `SMC_POLY_REF_HZ))
`define SMC_DRIVE_HALF (`SMC_CLK_HZ / (2 * `SMC_DRIVE_REF_HZ))

// ----------------------------------------------------------------
// Lock detection and scan timing
// ----------------------------------------------------------------
`define SMC_LOCK_TOL_SHIFT 4
`define SMC_LOCK_GOOD 4'h8
`define SMC_CNT_MAX 16'hffff
`define SMC_LSYNC_W 3'h4
`define SMC_FACES 3'h6
`define SMC_LASER_RST 8'h80
`define SMC_SPEED_RST 8'h00

// ----------------------------------------------------------------
// Controller register map and fields
// ----------------------------------------------------------------
`define SMC_REG_CTRL 8'h00
`define SMC_REG_STATUS 8'h04
`define SMC_REG_LINES 8'h08
`define SMC_CTRL_RST 6'h00
`define SMC_CTRL_POLY 0
`define SMC_CTRL_DRIVE 1
`define SMC_CTRL_DIR 2
`define SMC_CTRL_BRAKE 3
`define SMC_CTRL_LASER 4
`define SMC_CTRL_IMAGE 5

`endif

// file: src/smc_pkg.sv
package smc_pkg;
  typedef logic [31:0] smc_word_t;
  typedef logic [7:0] smc_addr_t;
  typedef logic [7:0] smc_speed_t;
  typedef enum logic [1:0] {SMC_IDLE, SMC_WAIT_LOCK, SMC_XFER} smc_xfer_e;
endpackage

// file: src/smc_link_if.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Link between the controller and the two motor drivers
// ----------------------------------------------------------------
interface smc_link_if;
  logic polygon_run_n;
  logic polygon_ref_clock;
  logic polygon_locked_n;
  logic drive_motor_run_n;
  logic drive_motor_direction;
  logic drive_motor_ref_clock;
  logic drive_motor_locked_n;
  logic drive_motor_brake_n;
  logic laser_gate_n;
  logic line_sync_n;

  modport ctrl_mp (
    output polygon_run_n,
    output polygon_ref_clock,
    input polygon_locked_n,
    output drive_motor_run_n,
    output drive_motor_direction,
    output drive_motor_ref_clock,
    input drive_motor_locked_n,
    output drive_motor_brake_n,
    output laser_gate_n,
    input line_sync_n
  );

  modport motor_mp (
    input polygon_run_n,
    input polygon_ref_clock,
    output polygon_locked_n,
    input drive_motor_run_n,
    input drive_motor_direction,
    input drive_motor_ref_clock,
    output drive_motor_locked_n,
    input drive_motor_brake_n,
    input laser_gate_n,
    output line_sync_n
  );
endinterface

// file: src/smc_motor_end.sv
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_motor_end (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  smc_link_if.motor_mp link,
  input wire logic [2:0] hall_sense,
  input wire logic poly_speed_pulse,
  input wire logic speed_feedback_pulse,
  input wire logic beam_detect,
  input wire logic power_low,
  input wire logic power_high,
  output logic polygon_motor_on,
  output smc_pkg::smc_speed_t polygon_speed_cmd,
  output logic [5:0] phase_drive,
  output smc_pkg::smc_speed_t laser_current,
  output logic laser_emit,
  output logic [2:0] face_index,
  output logic revolution_pulse
);
  import smc_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int IX_PRUN = 14;
  localparam int IX_PREF = 13;
  localparam int IX_DRUN = 12;
  localparam int IX_DDIR = 11;
  localparam int IX_DREF = 10;
  localparam int IX_BRK = 9;
  localparam int IX_GATE = 8;
  localparam int IX_PFB = 4;
  localparam int IX_DFB = 3;
  localparam int IX_BEAM = 2;
  localparam int IX_PLO = 1;
  localparam int IX_PHI = 0;
  // Active-low commands rest at their inactive level through reset.
  localparam logic [14:0] SYNC_RST = 15'h5300;
  // Hall code to {uh,ul,vh,vl,wh,wl} for clockwise rotation.
  localparam logic [7:0][5:0] COMM_TBL = {6'h00, 6'h18, 6'h06, 6'h12,
                                          6'h21, 6'h09, 6'h24, 6'h00};

  logic [14:0] s1_r, s2_r, s3_r, f_r, fp_r;
  wire [14:0] raw = {link.polygon_run_n, link.polygon_ref_clock,
                     link.drive_motor_run_n, link.drive_motor_direction,
                     link.drive_motor_ref_clock, link.drive_motor_brake_n,
                     link.laser_gate_n, hall_sense, poly_speed_pulse,
                     speed_feedback_pulse, beam_detect, power_low, power_high};
  // A bit only moves once the second and third stage agree.
  wire [14:0] agree = ~(s2_r ^ s3_r);
  wire [14:0] f_nxt = (s2_r & agree) | (f_r & ~agree);

  // Three-stage chain plus filtered copy and its previous value.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
      s3_r <= SYNC_RST;
      f_r <= SYNC_RST;
      fp_r <= SYNC_RST;
    end else if (ce) begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      f_r <= f_nxt;
      fp_r <= f_r;
    end
  end

  // ----------------------------------------------------------------
  // Decoded commands and edges
  // ----------------------------------------------------------------
  wire poly_run = !f_r[IX_PRUN];
  wire drive_run = !f_r[IX_DRUN];
  wire brake_on = !f_r[IX_BRK];
  wire dir_ccw = f_r[IX_DDIR];
  wire [2:0] hall = f_r[7:5];
  wire beam_rise = f_r[IX_BEAM] & ~fp_r[IX_BEAM];
  wire [1:0] run = {drive_run, poly_run};
  wire [1:0] ref_rise = {f_r[IX_DREF] & ~fp_r[IX_DREF], f_r[IX_PREF] & ~fp_r[IX_PREF]};
  wire [1:0] fb_rise = {f_r[IX_DFB] & ~fp_r[IX_DFB], f_r[IX_PFB] & ~fp_r[IX_PFB]};
  wire [1:0] locked;
  wire [1:0][7:0] speed;

  // ----------------------------------------------------------------
  // Speed loop and lock detector, index 0 polygon, index 1 main motor
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_loop
    logic [15:0] ref_cnt_r, ref_per_r, fb_cnt_r;
    logic [3:0] good_r;
    logic lag_r, lead_r, locked_r;
    logic [7:0] speed_r;
    wire [15:0] gap = (fb_cnt_r > ref_per_r) ? fb_cnt_r - ref_per_r : ref_per_r - fb_cnt_r;
    wire in_tol = (ref_per_r != 16'h0000) && (gap <= (ref_per_r >> `SMC_LOCK_TOL_SHIFT));
    wire speed_up = ref_rise[g] && !fb_rise[g] && lag_r && (speed_r != 8'hff);
    wire speed_dn = fb_rise[g] && !ref_rise[g] && lead_r && (speed_r != 8'h00);

    assign locked[g] = locked_r;
    assign speed[g] = speed_r;

    // Period counters saturate so a stopped motor reads as far too slow.
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        ref_cnt_r <= 16'h0000;
        ref_per_r <= 16'h0000;
        fb_cnt_r <= 16'h0000;
      end else if (ce) begin
        if (ref_rise[g]) begin
          ref_per_r <= ref_cnt_r;
          ref_cnt_r <= 16'h0001;
        end else if (ref_cnt_r != `SMC_CNT_MAX) begin
          ref_cnt_r <= ref_cnt_r + 16'h0001;
        end
        if (fb_rise[g]) begin
          fb_cnt_r <= 16'h0001;
        end else if (fb_cnt_r != `SMC_CNT_MAX) begin
          fb_cnt_r <= fb_cnt_r + 16'h0001;
        end
      end
    end

    // Several good periods in a row are needed, so one lucky edge
    // never reports a lock.
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        good_r <= 4'h0;
        locked_r <= 1'b0;
      end else if (ce) begin
        if (!run[g] || (fb_rise[g] && !in_tol) || fb_cnt_r == `SMC_CNT_MAX) begin
          good_r <= 4'h0;
        end else if (fb_rise[g] && good_r != `SMC_LOCK_GOOD) begin
          good_r <= good_r + 4'h1;
        end
        locked_r <= run[g] && (good_r == `SMC_LOCK_GOOD) && (fb_cnt_r != `SMC_CNT_MAX);
      end
    end

    // Phase-frequency compare: a reference edge with no feedback edge
    // since the last one means lag, and the reverse means lead.
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        lag_r <= 1'b0;
        lead_r <= 1'b0;
        speed_r <= `SMC_SPEED_RST;
      end else if (ce) begin
        if (!run[g]) begin
          lag_r <= 1'b0;
          lead_r <= 1'b0;
          speed_r <= `SMC_SPEED_RST;
        end else begin
          lag_r <= ref_rise[g] | (lag_r & ~fb_rise[g]);
          lead_r <= fb_rise[g] | (lead_r & ~ref_rise[g]);
          if (speed_up) begin
            speed_r <= speed_r + 8'h01;
          end else if (speed_dn) begin
            speed_r <= speed_r - 8'h01;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Commutation of the main motor
  // ----------------------------------------------------------------
  logic [7:0] pwm_r;
  logic [5:0] phase_r;
  wire [5:0] comm_cw = COMM_TBL[hall];
  // Reversing swaps the high and low switch of each winding.
  wire [5:0] comm_sel = dir_ccw ? {comm_cw[4], comm_cw[5], comm_cw[2], comm_cw[3],
                                   comm_cw[0], comm_cw[1]} : comm_cw;
  wire [5:0] hi_mask = (pwm_r < speed[1]) ? 6'h3f : 6'h15;
  // Braking shorts all windings through the low switches.
  wire [5:0] phase_nxt = brake_on ? 6'h15 : (!drive_run ? 6'h00 : comm_sel & hi_mask);

  // Free-running PWM base and registered switch drive.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwm_r <= 8'h00;
      phase_r <= 6'h00;
    end else if (ce) begin
      pwm_r <= pwm_r + 8'h01;
      phase_r <= phase_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Scan line sync, face count and laser power trim
  // ----------------------------------------------------------------
  logic [2:0] lsync_cnt_r, face_r;
  logic line_sync_n_r, rev_r, emit_r, pmotor_r;
  logic poly_locked_n_r, drive_locked_n_r;
  logic [7:0] laser_r;
  wire scan_evt = beam_rise && poly_run;
  wire face_wrap = (face_r == `SMC_FACES - 3'h1);

  // The line sync is stretched so a slower sampler still sees it.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lsync_cnt_r <= 3'h0;
      line_sync_n_r <= 1'b1;
      face_r <= 3'h0;
      rev_r <= 1'b0;
    end else if (ce) begin
      if (scan_evt) begin
        lsync_cnt_r <= `SMC_LSYNC_W;
        face_r <= face_wrap ? 3'h0 : face_r + 3'h1;
      end else if (lsync_cnt_r != 3'h0) begin
        lsync_cnt_r <= lsync_cnt_r - 3'h1;
      end
      line_sync_n_r <= !(scan_evt || lsync_cnt_r > 3'h1);
      rev_r <= scan_evt && face_wrap;
    end
  end

  // Power is trimmed only at a scan so the step size stays per line.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      laser_r <= `SMC_LASER_RST;
    end else if (ce && scan_evt) begin
      if (f_r[IX_PLO] && !f_r[IX_PHI] && laser_r != 8'hff) begin
        laser_r <= laser_r + 8'h01;
      end else if (f_r[IX_PHI] && !f_r[IX_PLO] && laser_r != 8'h00) begin
        laser_r <= laser_r - 8'h01;
      end
    end
  end

  // Status and run outputs.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      emit_r <= 1'b0;
      pmotor_r <= 1'b0;
      poly_locked_n_r <= 1'b1;
      drive_locked_n_r <= 1'b1;
    end else if (ce) begin
      emit_r <= !f_r[IX_GATE] && poly_run;
      pmotor_r <= poly_run;
      poly_locked_n_r <= !locked[0];
      drive_locked_n_r <= !locked[1];
    end
  end

  assign link.polygon_locked_n = poly_locked_n_r;
  assign link.drive_motor_locked_n = drive_locked_n_r;
  assign link.line_sync_n = line_sync_n_r;
  assign polygon_motor_on = pmotor_r;
  assign polygon_speed_cmd = speed[0];
  assign phase_drive = phase_r;
  assign laser_current = laser_r;
  assign laser_emit = emit_r;
  assign face_index = face_r;
  assign revolution_pulse = rev_r;
endmodule

// file: src/smc_ctrl_end.sv
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_ctrl_end (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire smc_pkg::smc_addr_t addr,
  input wire smc_pkg::smc_word_t wdata,
  input wire logic wr,
  input wire logic rd,
  output smc_pkg::smc_word_t rdata,
  output logic image_go,
  smc_link_if.ctrl_mp link
);
  import smc_pkg::*;

  // ----------------------------------------------------------------
  // Synchronisers for the status pins
  // ----------------------------------------------------------------
  logic [2:0] s1_r, s2_r, s3_r, f_r, fp_r;
  wire [2:0] raw = {link.line_sync_n, link.drive_motor_locked_n, link.polygon_locked_n};
  wire [2:0] agree = ~(s2_r ^ s3_r);
  wire [2:0] f_nxt = (s2_r & agree) | (f_r & ~agree);

  // All pins idle high, so reset leaves them reading unlocked.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= 3'h7;
      s2_r <= 3'h7;
      s3_r <= 3'h7;
      f_r <= 3'h7;
      fp_r <= 3'h7;
    end else if (ce) begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      f_r <= f_nxt;
      fp_r <= f_r;
    end
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic [5:0] ctrl_r;
  logic [15:0] lines_r;
  logic gate_n_r, go_r;
  logic prun_n_r, drun_n_r, brake_n_r;
  smc_word_t rdata_r;
  smc_xfer_e state_r, state_nxt;
  wire poly_locked = !f_r[0] && ctrl_r[`SMC_CTRL_POLY];
  wire drive_locked = !f_r[1] && ctrl_r[`SMC_CTRL_DRIVE];
  wire line_evt = !f_r[2] && fp_r[2];
  wire wr_ctrl = wr && (addr == `SMC_REG_CTRL);
  wire wr_lines = wr && (addr == `SMC_REG_LINES);
  wire [31:0] status = {28'h0000000, go_r, !gate_n_r, drive_locked, poly_locked};
  wire [31:0] rd_mux = (addr == `SMC_REG_CTRL) ? {26'h0000000, ctrl_r} :
                       (addr == `SMC_REG_STATUS) ? status :
                       (addr == `SMC_REG_LINES) ? {16'h0000, lines_r} : 32'h00000000;

  // Control register, line counter and read port; a line event in the
  // clearing cycle still counts as one.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `SMC_CTRL_RST;
      prun_n_r <= 1'b1;
      drun_n_r <= 1'b1;
      brake_n_r <= 1'b1;
      lines_r <= 16'h0000;
      rdata_r <= 32'h00000000;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_r <= wdata[5:0];
        prun_n_r <= !wdata[`SMC_CTRL_POLY];
        drun_n_r <= !wdata[`SMC_CTRL_DRIVE];
        brake_n_r <= !wdata[`SMC_CTRL_BRAKE];
      end
      if (wr_lines) begin
        lines_r <= {15'h0000, line_evt};
      end else if (line_evt) begin
        lines_r <= lines_r + 16'h0001;
      end
      rdata_r <= rd ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Reference clock dividers
  // ----------------------------------------------------------------
  logic [15:0] pdiv_r, ddiv_r;
  logic pref_r, dref_r;
  wire pdiv_end = (pdiv_r == 16'(`SMC_POLY_HALF - 1));
  wire ddiv_end = (ddiv_r == 16'(`SMC_DRIVE_HALF - 1));

  // Each reference runs only while its motor is commanded on.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pdiv_r <= 16'h0000;
      ddiv_r <= 16'h0000;
      pref_r <= 1'b0;
      dref_r <= 1'b0;
    end else if (ce) begin
      pdiv_r <= (pdiv_end || !ctrl_r[`SMC_CTRL_POLY]) ? 16'h0000 : pdiv_r + 16'h0001;
      ddiv_r <= (ddiv_end || !ctrl_r[`SMC_CTRL_DRIVE]) ? 16'h0000 : ddiv_r + 16'h0001;
      pref_r <= ctrl_r[`SMC_CTRL_POLY] && (pref_r ^ pdiv_end);
      dref_r <= ctrl_r[`SMC_CTRL_DRIVE] && (dref_r ^ ddiv_end);
    end
  end

  // ----------------------------------------------------------------
  // Laser gate and image transfer sequencing
  // ----------------------------------------------------------------
  wire xfer_req = ctrl_r[`SMC_CTRL_IMAGE];
  wire all_locked = drive_locked && poly_locked;

  // Transfer waits for both locks and aborts the moment either goes.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SMC_IDLE: begin
        if (xfer_req) begin
          state_nxt = SMC_WAIT_LOCK;
        end
      end
      SMC_WAIT_LOCK: begin
        if (!xfer_req) begin
          state_nxt = SMC_IDLE;
        end else if (all_locked) begin
          state_nxt = SMC_XFER;
        end
      end
      SMC_XFER: begin
        if (!xfer_req || !all_locked) begin
          state_nxt = SMC_IDLE;
        end
      end
      default: begin
        state_nxt = SMC_IDLE;
      end
    endcase
  end

  // Gate goes off within one cycle of the filtered unlock.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= SMC_IDLE;
      go_r <= 1'b0;
      gate_n_r <= 1'b1;
    end else if (ce) begin
      state_r <= state_nxt;
      go_r <= (state_nxt == SMC_XFER);
      gate_n_r <= !(ctrl_r[`SMC_CTRL_LASER] && poly_locked);
    end
  end

  assign link.polygon_run_n = prun_n_r;
  assign link.polygon_ref_clock = pref_r;
  assign link.drive_motor_run_n = drun_n_r;
  assign link.drive_motor_direction = ctrl_r[`SMC_CTRL_DIR];
  assign link.drive_motor_ref_clock = dref_r;
  assign link.drive_motor_brake_n = brake_n_r;
  assign link.laser_gate_n = gate_n_r;
  assign rdata = rdata_r;
  assign image_go = go_r;
endmodule

// file: test/smc_link_checker.sv
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_link_checker (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic polygon_run_n,
  input wire logic polygon_ref_clock,
  input wire logic polygon_locked_n,
  input wire logic drive_motor_run_n,
  input wire logic drive_motor_direction,
  input wire logic drive_motor_ref_clock,
  input wire logic drive_motor_locked_n,
  input wire logic drive_motor_brake_n,
  input wire logic laser_gate_n,
  input wire logic line_sync_n
);
  // ----------------------------------------------------------------
  // Polygon reference half period
  // ----------------------------------------------------------------
  logic ref_q_r;
  logic seen_r;
  logic [15:0] half_cnt_r;
  wire logic ref_edge = ref_q_r != polygon_ref_clock;

  // The first toggle after a start only arms the count, as its phase is free.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ref_q_r <= 1'b0;
      seen_r <= 1'b0;
      half_cnt_r <= 16'h0000;
    end else begin
      ref_q_r <= polygon_ref_clock;
      seen_r <= polygon_run_n ? 1'b0 : (seen_r | ref_edge);
      half_cnt_r <= ref_edge ? 16'h0001 : half_cnt_r + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // Link relations
  // ----------------------------------------------------------------
  a_sync_pulse_width: assert property (
    $fell(line_sync_n) |-> !line_sync_n [*4] ##1 line_sync_n)
    else $error("line sync pulse is not four cycles long");
  a_gate_drops_unlock: assert property (
    $rose(polygon_locked_n) |-> ##[0:10] laser_gate_n)
    else $error("laser gate kept on after polygon unlock");
  a_gate_needs_lock: assert property (
    $fell(laser_gate_n) |-> !polygon_locked_n)
    else $error("laser gate opened without polygon lock");
  a_poly_stop_unlock: assert property (
    $rose(polygon_run_n) |-> ##[0:10] polygon_locked_n)
    else $error("polygon still locked after stop");
  a_drive_stop_unlock: assert property (
    $rose(drive_motor_run_n) |-> ##[0:10] drive_motor_locked_n)
    else $error("main motor still locked after stop");
  a_poly_lock_run: assert property (
    $fell(polygon_locked_n) |-> !polygon_run_n && !$past(polygon_run_n, 8))
    else $error("polygon locked without running");
  a_drive_lock_run: assert property (
    $fell(drive_motor_locked_n) |-> !drive_motor_run_n && !$past(drive_motor_run_n, 8))
    else $error("main motor locked without running");
  a_poly_ref_half: assert property (
    ref_edge && seen_r && !polygon_run_n |-> half_cnt_r == `SMC_POLY_HALF)
    else $error("polygon reference half period wrong");
  a_drive_ref_idle: assert property (
    drive_motor_run_n && $past(drive_motor_run_n) |-> !$rose(drive_motor_ref_clock))
    else $error("main reference clock runs while stopped");
endmodule

// file: test/scanner_and_drive_motor_control_bench.sv
`timescale 1ns/1ps
`include "smc_consts.svh"
`define CHK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("Error %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module scanner_and_drive_motor_control_bench;
  import smc_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  smc_addr_t addr = 8'h00;
  smc_word_t wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  smc_word_t rdata;
  logic image_go;
  logic [2:0] hall = 3'h1;
  logic poly_tach = 1'b0;
  logic fb_tach = 1'b0;
  logic beam = 1'b0;
  logic pw_low = 1'b0;
  logic pw_high = 1'b0;
  logic echo_on = 1'b0;
  logic motor_on;
  smc_speed_t poly_cmd;
  logic [5:0] phase;
  smc_speed_t laser_cur;
  logic emit;
  logic [2:0] face;
  logic rev;
  logic sync_q = 1'b1;
  int fails = 0;
  int samples_checked = 0;
  int revs = 0;
  int syncs = 0;

  smc_link_if link ();
  smc_ctrl_end smc_ctrl_end_i (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .image_go(image_go), .link(link.ctrl_mp));
  smc_motor_end smc_motor_end_i (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
    .link(link.motor_mp), .hall_sense(hall), .poly_speed_pulse(poly_tach),
    .speed_feedback_pulse(fb_tach), .beam_detect(beam), .power_low(pw_low),
    .power_high(pw_high), .polygon_motor_on(motor_on), .polygon_speed_cmd(poly_cmd),
    .phase_drive(phase), .laser_current(laser_cur), .laser_emit(emit),
    .face_index(face), .revolution_pulse(rev));
  smc_link_checker smc_link_checker_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .polygon_run_n(link.polygon_run_n), .polygon_ref_clock(link.polygon_ref_clock),
    .polygon_locked_n(link.polygon_locked_n), .drive_motor_run_n(link.drive_motor_run_n),
    .drive_motor_direction(link.drive_motor_direction),
    .drive_motor_ref_clock(link.drive_motor_ref_clock),
    .drive_motor_locked_n(link.drive_motor_locked_n),
    .drive_motor_brake_n(link.drive_motor_brake_n), .laser_gate_n(link.laser_gate_n),
    .line_sync_n(link.line_sync_n));

  always #12.5 clk_sys = ~clk_sys;

  // Tachometers echo the reference clocks, the polygon one only while echo_on is set, so each motor then runs at its target speed.
  always @(posedge clk_sys) begin
    if (echo_on) poly_tach <= link.polygon_ref_clock;
    fb_tach <= link.drive_motor_ref_clock;
  end

  // Counts on the falling edge, away from the edge where the outputs move.
  always @(negedge clk_sys) begin
    sync_q <= link.line_sync_n;
    if (rev === 1'b1) revs <= revs + 1;
    if (sync_q === 1'b1 && link.line_sync_n === 1'b0) syncs <= syncs + 1;
  end

  // ----------------------------------------------------------------
  // Bus and helper tasks
  // ----------------------------------------------------------------
  task automatic wr_reg(input smc_addr_t a, input smc_word_t d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd_chk(input smc_addr_t a, input smc_word_t exp, input string what);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    `CHK(what, exp, rdata)
  endtask

  task automatic beam_once();
    @(posedge clk_sys);
    beam <= 1'b1;
    repeat (6) @(posedge clk_sys);
    beam <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic stop_test();
    if (fails == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_pins();
    `CHK("poly run", 1'b1, link.polygon_run_n)
    `CHK("drive run", 1'b1, link.drive_motor_run_n)
    `CHK("brake", 1'b1, link.drive_motor_brake_n)
    `CHK("gate", 1'b1, link.laser_gate_n)
    `CHK("current", 8'h80, laser_cur)
    `CHK("motor on", 1'b0, motor_on)
    wr_reg(`SMC_REG_CTRL, 32'h0000000c);
    `CHK("direction", 1'b1, link.drive_motor_direction)
    `CHK("brake", 1'b0, link.drive_motor_brake_n)
    rd_chk(`SMC_REG_CTRL, 32'h0000000c, "ctrl");
    wr_reg(`SMC_REG_STATUS, 32'hffffffff);
    rd_chk(`SMC_REG_STATUS, 32'h00000000, "status");
    rd_chk(8'h0c, 32'h00000000, "unmapped");
    `CHK("phase", 6'h15, phase)
    wr_reg(`SMC_REG_CTRL, 32'h00000000);
    `CHK("direction", 1'b0, link.drive_motor_direction)
    `CHK("brake", 1'b1, link.drive_motor_brake_n)
  endtask

  // Twelve scans make two revolutions; the power loop steps once per scan.
  task automatic t_scan();
    int r0;
    int s0;
    beam_once();
    rd_chk(`SMC_REG_LINES, 32'h00000000, "lines idle");
    wr_reg(`SMC_REG_CTRL, 32'h00000001);
    `CHK("poly run", 1'b0, link.polygon_run_n)
    `CHK("drive run", 1'b1, link.drive_motor_run_n)
    repeat (8) @(posedge clk_sys);
    `CHK("motor on", 1'b1, motor_on)
    r0 = revs;
    s0 = syncs;
    pw_low <= 1'b1;
    repeat (12) beam_once();
    `CHK("face", 3'h0, face)
    `CHK("revs", 2, revs - r0)
    `CHK("syncs", 12, syncs - s0)
    `CHK("current", 8'h8c, laser_cur)
    rd_chk(`SMC_REG_LINES, 32'h0000000c, "lines");
    pw_low <= 1'b0;
    pw_high <= 1'b1;
    repeat (2) beam_once();
    `CHK("current", 8'h8a, laser_cur)
    `CHK("face", 3'h2, face)
    pw_low <= 1'b1;
    beam_once();
    `CHK("current", 8'h8a, laser_cur)
    wr_reg(`SMC_REG_LINES, 32'h00000000);
    rd_chk(`SMC_REG_LINES, 32'h00000000, "lines clear");
    pw_low <= 1'b0;
    pw_high <= 1'b0;
  endtask

  // Both motors are started together so the long lock waits overlap.
  task automatic t_lock();
    int n;
    echo_on <= 1'b1;
    wr_reg(`SMC_REG_CTRL, 32'h00000013);
    hall <= 3'h0;
    repeat (10) @(posedge clk_sys);
    `CHK("phase", 6'h00, phase)
    hall <= 3'h7;
    repeat (10) @(posedge clk_sys);
    `CHK("phase", 6'h00, phase)
    hall <= 3'h5;
    n = 0;
    while (link.polygon_locked_n !== 1'b0 && n < 60000) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK("poly lock", 1'b0, link.polygon_locked_n)
    repeat (12) @(posedge clk_sys);
    `CHK("gate", 1'b0, link.laser_gate_n)
    `CHK("emit", 1'b1, emit)
    n = 0;
    while (link.drive_motor_locked_n !== 1'b0 && n < 100000) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK("drive lock", 1'b0, link.drive_motor_locked_n)
    wr_reg(`SMC_REG_CTRL, 32'h00000033);
    repeat (12) @(posedge clk_sys);
    `CHK("image go", 1'b1, image_go)
    rd_chk(`SMC_REG_STATUS, 32'h0000000f, "status");
    echo_on <= 1'b0;
    repeat (9000) @(posedge clk_sys);
    `CHK("speed up", 1'b1, poly_cmd != 8'h00)
    echo_on <= 1'b1;
    n = 0;
    while (link.polygon_locked_n !== 1'b1 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK("poly unlock", 1'b1, link.polygon_locked_n)
    repeat (12) @(posedge clk_sys);
    `CHK("gate", 1'b1, link.laser_gate_n)
    `CHK("image stop", 1'b0, image_go)
    wr_reg(`SMC_REG_CTRL, 32'h00000000);
    repeat (12) @(posedge clk_sys);
    `CHK("drive unlock", 1'b1, link.drive_motor_locked_n)
    `CHK("motor on", 1'b0, motor_on)
  endtask

  // Reset, the scenarios and the verdict.
  initial begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    #1;
    t_pins();
    t_scan();
    t_lock();
    stop_test();
  end

  // The lock waits dominate the run; this limit leaves them ample room.
  initial begin
    repeat (90000) @(posedge clk_sys);
    fails++;
    stop_test();
  end
endmodule
